//--- rtl/ilp_ctrl.sv
`timescale 1ns/1ps
module ilp_ctrl
  import ilp_pkg::*;
(
  // Clock and reset (reset is the power-on event)
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Special-function register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // Reset and non-maskable sources
  input wire logic i_pin_reset,
  input wire logic i_pin_nmi,
  input wire logic i_osc_fault,
  input wire logic i_flash_key_violation,
  input wire logic i_flash_access_violation,
  // Watchdog
  input wire logic i_wdt_expire,
  input wire logic i_wdt_interval_mode,
  input wire logic i_wdt_hold,
  // Module-held interrupt flags
  input wire ilp_mod_irq_t i_mod_irq,
  // CPU side
  input wire logic i_gie,
  input wire logic i_mode_req,
  input wire ilp_mode_t i_mode_sel,
  input wire logic i_irq_ack,
  input wire logic i_irq_return,
  input wire logic i_fetch_valid,
  input wire logic [15:0] i_fetch_addr,
  input wire logic [15:0] i_reset_vector_word,
  input wire logic i_boot_check,
  input wire logic i_digital_osc_used_active,
  input wire logic i_aux_sel_lf,
  output logic o_irq_req,
  output logic [15:0] o_irq_vector,
  output logic [4:0] o_irq_priority,
  output logic o_sys_reset,
  output ilp_mode_t o_mode,
  output ilp_clk_t o_clk
);

  logic [7:0] ie1_q;
  logic [7:0] ifg1_q;
  ilp_mode_t mode_q;
  ilp_mode_t saved_mode_q;
  logic in_handler_q;
  logic sys_reset_q;
  logic [15:0] vec_q;
  logic [4:0] pri_q;
  logic req_q;
  logic fetch_bad;
  logic wdt_rst_evt;
  logic [7:0] ifg1_set;

  // Peripheral register space at or below PERIPH_TOP is not code
  assign fetch_bad = i_fetch_valid && (i_fetch_addr <= PERIPH_TOP); // RQ11
  assign wdt_rst_evt = !i_wdt_hold && !i_wdt_interval_mode && i_wdt_expire; // RQ22

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sys_reset_q <= 1'b1;
    end else begin
      sys_reset_q <= i_pin_reset || wdt_rst_evt || i_flash_key_violation
                     || fetch_bad; // RQ10 RQ11 RQ22
    end
  end

  always_comb begin
    ifg1_set = 8'h00;
    ifg1_set[B_WDT] = wdt_rst_evt || i_flash_key_violation; // RQ18
    ifg1_set[B_OSC] = i_osc_fault; // RQ19
    ifg1_set[B_RST] = i_pin_reset;
    ifg1_set[B_NMI] = i_pin_nmi;
  end

  // Power-up clear: enables drop on every system reset, not only power-on
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ie1_q <= IE1_RESET; // RQ17
    end else if (sys_reset_q) begin
      ie1_q <= IE1_RESET; // RQ17
    end else if (i_sfr_wr && i_sfr_addr == IE1_ADDR) begin
      ie1_q <= i_sfr_wdata & IE1_MASK; // RQ20
    end
  end

  // Interval-mode watchdog event flag, kept outside the reset flags
  logic wdt_int_q;
  logic acc_q;
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wdt_int_q <= 1'b0;
      acc_q <= 1'b0;
    end else begin
      if (i_wdt_expire && i_wdt_interval_mode && !i_wdt_hold) begin
        wdt_int_q <= 1'b1;
      end else if (i_irq_ack && req_q && vec_q == VEC_WDT) begin
        wdt_int_q <= 1'b0;
      end
      if (i_flash_access_violation) begin
        acc_q <= 1'b1;
      end else if (i_irq_ack && req_q && vec_q == VEC_NMI) begin
        acc_q <= 1'b0;
      end
    end
  end

  // Next flag value: software write first, then hardware clears, then sets
  logic [7:0] ifg1_d;
  always_comb begin
    ifg1_d = ifg1_q;
    if (i_sfr_wr && i_sfr_addr == IFG1_ADDR) begin
      ifg1_d = i_sfr_wdata & IFG1_MASK;
    end
    // A pin reset wipes the old watchdog cause
    if (i_pin_reset) begin
      ifg1_d[B_WDT] = 1'b0; // RQ18
    end
    // Hardware events win over a clear in the same cycle
    ifg1_d = ifg1_d | ifg1_set;
    if (sys_reset_q) begin
      ifg1_d = ifg1_d | IFG1_PUC_SET; // RQ19
    end
  end

  // Power-on sets its flag and clears watchdog and pin-reset flags
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ifg1_q <= 8'h06; // RQ18 RQ19
    end else begin
      ifg1_q <= ifg1_d;
    end
  end

  always_comb begin
    o_sfr_rdata = 8'h00;
    if (i_sfr_rd && i_sfr_addr == IE1_ADDR) begin
      o_sfr_rdata = ie1_q & IE1_MASK; // RQ20
    end else if (i_sfr_rd && i_sfr_addr == IFG1_ADDR) begin
      o_sfr_rdata = ifg1_q & IFG1_MASK;
    end else if (i_sfr_rd && (i_sfr_addr == IE2_ADDR || i_sfr_addr == IFG2_ADDR)) begin
      o_sfr_rdata = 8'h00; // RQ20
    end
  end

  // Fixed-priority arbiter; only listed vectors can ever be produced
  logic nmi_pend;
  logic wdt_pend;
  logic mask_ok;
  always_comb begin
    nmi_pend = (ie1_q[B_NMI] && ifg1_q[B_NMI]) || (ie1_q[B_OSC] && ifg1_q[B_OSC])
               || (ie1_q[B_ACCV] && acc_q); // RQ12
    wdt_pend = ie1_q[B_WDT] && i_wdt_interval_mode && wdt_int_q; // RQ16
    mask_ok = i_gie && !in_handler_q;
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      req_q <= 1'b0;
      vec_q <= VEC_RESET;
      pri_q <= PRI_RESET;
    end else if (sys_reset_q) begin
      req_q <= 1'b1;
      vec_q <= VEC_RESET; // RQ10 RQ8
      pri_q <= PRI_RESET;
    end else if (i_irq_ack) begin
      req_q <= 1'b0;
    end else if (nmi_pend && !in_handler_q) begin
      req_q <= 1'b1;
      vec_q <= VEC_NMI; // RQ12
      pri_q <= PRI_NMI;
    end else if (mask_ok && i_mod_irq.comparator_flag) begin
      req_q <= 1'b1; // RQ23
      vec_q <= VEC_COMP;
      pri_q <= PRI_COMP;
    end else if (mask_ok && wdt_pend) begin
      req_q <= 1'b1;
      vec_q <= VEC_WDT; // RQ16
      pri_q <= PRI_WDT;
    end else if (mask_ok && i_mod_irq.capture_compare_0) begin
      req_q <= 1'b1;
      vec_q <= VEC_CC0; // RQ13
      pri_q <= PRI_CC0;
    end else if (mask_ok && (i_mod_irq.capture_compare_1 || i_mod_irq.timer_overflow_flag)) begin
      req_q <= 1'b1;
      vec_q <= VEC_CC1; // RQ13
      pri_q <= PRI_CC1;
    end else if (mask_ok && |i_mod_irq.port2_pin_flags) begin
      req_q <= 1'b1;
      vec_q <= VEC_P2; // RQ14
      pri_q <= PRI_P2;
    end else if (mask_ok && |i_mod_irq.port1_pin_flags) begin
      req_q <= 1'b1;
      vec_q <= VEC_P1; // RQ14 RQ15
      pri_q <= PRI_P1;
    end else begin
      // A raised request stands until the core takes it
      req_q <= req_q;
    end
  end

  // Sleep mode tracking: save on wake, restore on handler return
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_q <= full_run_state;
      saved_mode_q <= full_run_state;
      in_handler_q <= 1'b0;
    end else if (sys_reset_q) begin
      mode_q <= full_run_state;
      in_handler_q <= 1'b0;
    end else if (i_boot_check && i_reset_vector_word == BLANK_WORD) begin
      mode_q <= sleep_state_4; // RQ9
    end else if (i_irq_ack && req_q && vec_q != VEC_RESET) begin
      // Taking the reset vector is a restart, not a handler entry
      saved_mode_q <= mode_q; // RQ1
      mode_q <= full_run_state;
      in_handler_q <= 1'b1;
    end else if (i_irq_return && in_handler_q) begin
      mode_q <= saved_mode_q; // RQ1
      in_handler_q <= 1'b0;
    end else if (i_mode_req) begin
      mode_q <= i_mode_sel;
    end
  end

  // Every gate is spelled out per mode so no mode inherits a stale enable
  always_comb begin
    o_clk = '0;
    o_clk.aux_src_lf = i_aux_sel_lf; // RQ21
    case (mode_q)
      full_run_state: begin
        o_clk.aux_clk_en = 1'b1; // RQ2
        o_clk.main_clk_en = 1'b1;
        o_clk.sub_main_clk_en = 1'b1;
        o_clk.cpu_en = 1'b1;
        o_clk.digital_osc_gen_en = 1'b1;
        o_clk.crystal_en = 1'b1;
      end
      sleep_state_0: begin
        o_clk.aux_clk_en = 1'b1; // RQ3
        o_clk.main_clk_en = 1'b0;
        o_clk.sub_main_clk_en = 1'b1;
        o_clk.cpu_en = 1'b0;
        o_clk.digital_osc_gen_en = 1'b1;
        o_clk.crystal_en = 1'b1;
      end
      sleep_state_1: begin
        o_clk.aux_clk_en = 1'b1; // RQ3
        o_clk.main_clk_en = 1'b0;
        o_clk.sub_main_clk_en = 1'b1;
        o_clk.cpu_en = 1'b0;
        // Generator may only drop when nothing in run mode relies on it
        o_clk.digital_osc_gen_en = i_digital_osc_used_active; // RQ4
        o_clk.crystal_en = 1'b1;
      end
      sleep_state_2: begin
        o_clk.aux_clk_en = 1'b1; // RQ5
        o_clk.main_clk_en = 1'b0;
        o_clk.sub_main_clk_en = 1'b0;
        o_clk.cpu_en = 1'b0;
        // Kept powered to trade current for fast wake-up
        o_clk.digital_osc_gen_en = 1'b1;
        o_clk.crystal_en = 1'b1;
      end
      sleep_state_3: begin
        o_clk.aux_clk_en = 1'b1; // RQ6
        o_clk.main_clk_en = 1'b0;
        o_clk.sub_main_clk_en = 1'b0;
        o_clk.cpu_en = 1'b0;
        o_clk.digital_osc_gen_en = 1'b0;
        o_clk.crystal_en = 1'b1;
      end
      default: begin
        o_clk.aux_clk_en = 1'b0; // RQ7
        o_clk.main_clk_en = 1'b0;
        o_clk.sub_main_clk_en = 1'b0;
        o_clk.cpu_en = 1'b0;
        o_clk.digital_osc_gen_en = 1'b0;
        o_clk.crystal_en = 1'b0;
      end
    endcase
  end

  assign o_irq_req = req_q;
  assign o_irq_vector = vec_q;
  assign o_irq_priority = pri_q;
  assign o_sys_reset = sys_reset_q;
  assign o_mode = mode_q;

endmodule : ilp_ctrl

//--- rtl/ilp_pkg.sv
// How it works
// RQ1 - Enabled interrupt wakes, services, then restores sleep
// RQ2 - Full run: all three clocks, CPU on
// RQ3 - Sleep 0/1: CPU and main clock off
// RQ4 - Sleep 1: oscillator generator off if unused
// RQ5 - Sleep 2: main, sub-main off, generator on
// RQ6 - Sleep 3: main, sub-main, generator off
// RQ7 - Sleep 4: everything off, crystal stopped
// RQ8 - Vectors live in top address range
// RQ9 - Blank reset vector forces sleep 4
// RQ10 - Reset sources share top vector, priority 31
// RQ11 - Fetch from peripheral or unused space resets; only fetches at or below PERIPH_TOP reset here
// RQ12 - Non-maskable trio shares vector, own enables
// RQ13 - Timer compare 0 alone; compare 1 shares
// RQ14 - Port 2 then port 1 vectors
// RQ15 - Low vector words never fetched
// RQ16 - Watchdog enable only in interval mode
// RQ17 - Enable register bit layout, cleared by clear
// RQ18 - Watchdog flag set and clear conditions
// RQ19 - Power-on and oscillator fault flag behaviour
// RQ20 - Unassigned bits not implemented, read zero
// RQ21 - Auxiliary clock source select
// RQ22 - Watchdog expiry resets; disable or interval mode
// RQ23 - Highest pending priority serviced first
package ilp_pkg;
  localparam logic [7:0] IE1_ADDR = 8'h00;
  localparam logic [7:0] IE2_ADDR = 8'h01;
  localparam logic [7:0] IFG1_ADDR = 8'h02;
  localparam logic [7:0] IFG2_ADDR = 8'h03;
  localparam int B_WDT = 0;
  localparam int B_OSC = 1;
  localparam int B_POR = 2;
  localparam int B_RST = 3;
  localparam int B_NMI = 4;
  localparam int B_ACCV = 5;
  localparam logic [7:0] IE1_MASK = 8'h33;
  localparam logic [7:0] IFG1_MASK = 8'h1f;
  localparam logic [7:0] IE1_RESET = 8'h00;
  localparam logic [7:0] IFG1_PUC_SET = 8'h02;
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_NMI = 16'hfffc;
  localparam logic [15:0] VEC_COMP = 16'hfff6;
  localparam logic [15:0] VEC_WDT = 16'hfff4;
  localparam logic [15:0] VEC_CC0 = 16'hfff2;
  localparam logic [15:0] VEC_CC1 = 16'hfff0;
  localparam logic [15:0] VEC_P2 = 16'hffe6;
  localparam logic [15:0] VEC_P1 = 16'hffe4;
  localparam logic [15:0] BLANK_WORD = 16'hffff;
  localparam logic [15:0] PERIPH_TOP = 16'h01ff;
  localparam logic [4:0] PRI_RESET = 5'h1f;
  localparam logic [4:0] PRI_NMI = 5'h1e;
  localparam logic [4:0] PRI_COMP = 5'h1b;
  localparam logic [4:0] PRI_WDT = 5'h1a;
  localparam logic [4:0] PRI_CC0 = 5'h19;
  localparam logic [4:0] PRI_CC1 = 5'h18;
  localparam logic [4:0] PRI_P2 = 5'h13;
  localparam logic [4:0] PRI_P1 = 5'h12;
  typedef enum logic [2:0] {
    full_run_state, sleep_state_0, sleep_state_1,
    sleep_state_2, sleep_state_3, sleep_state_4
  } ilp_mode_t;
  typedef struct packed {
    logic aux_clk_en;
    logic main_clk_en;
    logic sub_main_clk_en;
    logic cpu_en;
    logic digital_osc_gen_en;
    logic crystal_en;
    logic aux_src_lf;
  } ilp_clk_t;
  typedef struct packed {
    logic [7:0] port1_pin_flags;
    logic [1:0] port2_pin_flags;
    logic capture_compare_0;
    logic capture_compare_1;
    logic timer_overflow_flag;
    logic comparator_flag;
  } ilp_mod_irq_t;
endpackage : ilp_pkg

//--- dv/ilp_ctrl_chk.sv
`timescale 1ns/1ps
module ilp_ctrl_chk
  import ilp_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Watched inputs
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_rd,
  input wire logic i_wdt_expire,
  input wire logic i_wdt_interval_mode,
  input wire logic i_wdt_hold,
  input wire logic i_irq_ack,
  input wire logic i_fetch_valid,
  input wire logic [15:0] i_fetch_addr,
  // Watched outputs
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_irq_req,
  input wire logic [15:0] o_irq_vector,
  input wire logic [4:0] o_irq_priority,
  input wire logic o_sys_reset,
  input wire ilp_mode_t o_mode,
  input wire ilp_clk_t o_clk
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  unmapped_zero_a: assert property (i_sfr_rd && (i_sfr_addr == IE2_ADDR ||
    i_sfr_addr == IFG2_ADDR) |-> o_sfr_rdata == 8'h00) else $error("unmapped read not zero");
  enable_bits_a: assert property (i_sfr_rd && i_sfr_addr == IE1_ADDR |->
    (o_sfr_rdata & ~IE1_MASK) == 8'h00) else $error("absent enable bit read as one");
  reset_pri_a: assert property (o_irq_req && o_irq_vector == VEC_RESET |->
    o_irq_priority == PRI_RESET) else $error("reset vector priority wrong");
  vector_range_a: assert property (o_irq_req |-> o_irq_vector >= 16'hffe4 &&
    !o_irq_vector[0]) else $error("vector outside used range");
  req_holds_a: assert property (o_irq_req && !i_irq_ack && !o_sys_reset |=>
    o_irq_req) else $error("pending request dropped");
  ack_wakes_a: assert property (i_irq_ack |=> o_mode == full_run_state)
    else $error("ack did not wake");
  run_clocks_a: assert property (o_mode == full_run_state |-> o_clk[6:3] == 4'hf)
    else $error("run clocks wrong");
  sleep0_clocks_a: assert property (o_mode == sleep_state_0 |->
    o_clk[6:3] == 4'ha) else $error("sleep 0 clocks wrong");
  sleep2_clocks_a: assert property (o_mode == sleep_state_2 |->
    o_clk[6:2] == 5'h11) else $error("sleep 2 clocks wrong");
  sleep3_clocks_a: assert property (o_mode == sleep_state_3 |->
    o_clk[6:2] == 5'h10) else $error("sleep 3 clocks wrong");
  sleep4_clocks_a: assert property (o_mode == sleep_state_4 |->
    o_clk[6:1] == 6'h00) else $error("sleep 4 clocks wrong");
  wdt_reset_a: assert property (i_wdt_expire && !i_wdt_interval_mode && !i_wdt_hold
    |=> o_sys_reset) else $error("watchdog expiry without reset");
  fetch_reset_a: assert property (i_fetch_valid && i_fetch_addr <= PERIPH_TOP
    |=> o_sys_reset) else $error("bad fetch without reset");
endmodule : ilp_ctrl_chk

bind ilp_ctrl ilp_ctrl_chk u_chk (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
  .i_sfr_addr(i_sfr_addr), .i_sfr_rd(i_sfr_rd), .i_wdt_expire(i_wdt_expire),
  .i_wdt_interval_mode(i_wdt_interval_mode), .i_wdt_hold(i_wdt_hold),
  .i_irq_ack(i_irq_ack), .i_fetch_valid(i_fetch_valid), .i_fetch_addr(i_fetch_addr),
  .o_sfr_rdata(o_sfr_rdata), .o_irq_req(o_irq_req), .o_irq_vector(o_irq_vector),
  .o_irq_priority(o_irq_priority), .o_sys_reset(o_sys_reset), .o_mode(o_mode),
  .o_clk(o_clk));

//--- dv/ilp_cpu_model.sv
`timescale 1ns/1ps
module ilp_cpu_model
  import ilp_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Request from the controller
  input wire logic i_irq_req,
  input wire logic [15:0] i_irq_vector,
  // Acknowledge and what was taken
  output logic o_irq_ack,
  output logic [15:0] o_last_vec,
  output logic [7:0] o_taken
);
  // Ack one cycle late, as a core finishing its instruction would
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_irq_ack <= 1'b0;
      o_last_vec <= 16'h0000;
      o_taken <= 8'h00;
    end else begin
      o_irq_ack <= i_irq_req && !o_irq_ack;
      if (o_irq_ack) begin
        o_last_vec <= i_irq_vector;
        o_taken <= o_taken + 8'h01;
      end
    end
  end
endmodule : ilp_cpu_model

//--- dv/ilp_ctrl_test.sv
`timescale 1ns/1ps
module ilp_ctrl_test;
  import ilp_pkg::*;
  logic i_core_clk = 1'b0, i_sys_rst = 1'b1, i_sfr_wr = 1'b0, i_sfr_rd = 1'b0;
  logic i_pin_nmi = 1'b0, i_osc_fault = 1'b0, i_wdt_expire = 1'b0, i_gie = 1'b0;
  logic i_mode_req = 1'b0, i_irq_return = 1'b0, i_fetch_valid = 1'b0, i_boot_check = 1'b0;
  logic i_osc_used = 1'b0, i_aux_sel_lf = 1'b0, o_irq_req, o_sys_reset, irq_ack;
  logic [7:0] i_sfr_addr = 8'h00, i_sfr_wdata = 8'h00, o_sfr_rdata, taken;
  logic [15:0] i_fetch_addr = 16'h0200, i_boot_word = 16'h0000, o_irq_vector, last_vec;
  logic [4:0] o_irq_priority;
  logic i_wdt_int = 1'b0;
  ilp_mode_t i_mode_sel = full_run_state, o_mode;
  ilp_mod_irq_t i_mod_irq = '0;
  ilp_clk_t o_clk;
  int n_mismatch = 0, total_checks = 0;
  always #20 i_core_clk = ~i_core_clk;
  // Unused fault sources stay quiet; the watchdog is never held, and its interval mode follows i_wdt_int
  ilp_ctrl dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .i_pin_reset(1'b0), .i_pin_nmi(i_pin_nmi),
    .i_osc_fault(i_osc_fault), .i_flash_key_violation(1'b0),
    .i_flash_access_violation(1'b0), .i_wdt_expire(i_wdt_expire),
    .i_wdt_interval_mode(i_wdt_int), .i_wdt_hold(1'b0), .i_mod_irq(i_mod_irq), .i_gie(i_gie),
    .i_mode_req(i_mode_req), .i_mode_sel(i_mode_sel), .i_irq_ack(irq_ack),
    .i_irq_return(i_irq_return), .i_fetch_valid(i_fetch_valid), .i_fetch_addr(i_fetch_addr),
    .i_reset_vector_word(i_boot_word), .i_boot_check(i_boot_check),
    .i_digital_osc_used_active(i_osc_used), .i_aux_sel_lf(i_aux_sel_lf),
    .o_irq_req(o_irq_req), .o_irq_vector(o_irq_vector), .o_irq_priority(o_irq_priority),
    .o_sys_reset(o_sys_reset), .o_mode(o_mode), .o_clk(o_clk));
  ilp_cpu_model cpu (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_irq_req(o_irq_req),
    .i_irq_vector(o_irq_vector), .o_irq_ack(irq_ack), .o_last_vec(last_vec), .o_taken(taken));
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr <= 1'b1;
    @(posedge i_core_clk);
    i_sfr_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge i_core_clk);
    i_sfr_addr <= a;
    i_sfr_rd <= 1'b1;
    @(negedge i_core_clk);
    chk(what, 16'(exp), 16'(o_sfr_rdata));
    @(posedge i_core_clk);
    i_sfr_rd <= 1'b0;
  endtask : rd
  task automatic go_mode(input ilp_mode_t m);
    @(posedge i_core_clk);
    i_mode_req <= 1'b1;
    i_mode_sel <= m;
    @(posedge i_core_clk);
    i_mode_req <= 1'b0;
    @(negedge i_core_clk);
  endtask : go_mode
  task automatic ret();
    @(posedge i_core_clk);
    i_irq_return <= 1'b1;
    @(posedge i_core_clk);
    i_irq_return <= 1'b0;
    @(negedge i_core_clk);
  endtask : ret
  task automatic wait_taken(input logic [7:0] n);
    for (int k = 0; k < 40 && taken !== n; k++) @(posedge i_core_clk);
    if (taken !== n) begin
      chk("ack count", 16'(n), 16'(taken));
      conclude();
    end
    @(negedge i_core_clk);
  endtask : wait_taken
  task automatic t_boot();
    wait_taken(8'h01);
    chk("power-up vector", VEC_RESET, last_vec);
    rd(IE1_ADDR, 8'h00, "enable reset");
    rd(IFG1_ADDR, 8'h06, "flag reset");
    wr(IFG1_ADDR, 8'h04);
    wr(IE1_ADDR, 8'hff);
    rd(IE1_ADDR, IE1_MASK, "enable bits");
    wr(IE2_ADDR, 8'hff);
    rd(IE2_ADDR, 8'h00, "absent register");
    wr(IE1_ADDR, 8'h00);
    @(posedge i_core_clk);
    i_pin_nmi <= 1'b1;
    i_osc_fault <= 1'b1;
    @(posedge i_core_clk);
    i_pin_nmi <= 1'b0;
    i_osc_fault <= 1'b0;
    rd(IFG1_ADDR, 8'h16, "fault flags");
    chk("blocked by enable", 16'h0001, 16'(taken));
    wr(IFG1_ADDR, 8'h00);
    rd(IFG1_ADDR, 8'h00, "flags cleared");
  endtask : t_boot
  task automatic t_modes();
    logic [5:0] exp [6] = '{6'h3f, 6'h2b, 6'h29, 6'h23, 6'h21, 6'h00};
    for (int m = 0; m < 6; m++) begin
      @(posedge i_core_clk);
      i_aux_sel_lf <= m[0];
      go_mode(ilp_mode_t'(m));
      chk("clock gates", 16'(exp[m]), 16'(o_clk[6:1]));
      chk("aux source", 16'(m[0]), 16'(o_clk.aux_src_lf));
      go_mode(full_run_state);
    end
    @(posedge i_core_clk);
    i_osc_used <= 1'b1;
    go_mode(sleep_state_1);
    chk("generator kept", 16'h0001, 16'(o_clk.digital_osc_gen_en));
    go_mode(full_run_state);
  endtask : t_modes
  task automatic t_wake();
    go_mode(sleep_state_3);
    @(posedge i_core_clk);
    i_gie <= 1'b1;
    i_mod_irq.capture_compare_0 <= 1'b1;
    i_mod_irq.port1_pin_flags <= 8'h80;
    wait_taken(8'h02);
    chk("first vector", VEC_CC0, last_vec);
    chk("woken", 16'(full_run_state), 16'(o_mode));
    @(posedge i_core_clk);
    i_mod_irq.capture_compare_0 <= 1'b0;
    ret();
    wait_taken(8'h03);
    chk("second vector", VEC_P1, last_vec);
    @(posedge i_core_clk);
    i_mod_irq.port1_pin_flags <= 8'h00;
    ret();
    chk("sleep restored", 16'(sleep_state_3), 16'(o_mode));
  endtask : t_wake
  task automatic t_interval();
    wr(IE1_ADDR, 8'h01);
    @(posedge i_core_clk);
    i_wdt_int <= 1'b1;
    i_wdt_expire <= 1'b1;
    @(posedge i_core_clk);
    i_wdt_expire <= 1'b0;
    wait_taken(8'h04);
    chk("interval vector", VEC_WDT, last_vec);
    chk("no interval reset", 16'h0000, 16'(o_sys_reset));
    ret();
    chk("interval sleep back", 16'(sleep_state_3), 16'(o_mode));
    @(posedge i_core_clk);
    i_wdt_int <= 1'b0;
  endtask : t_interval
  task automatic t_resets();
    wr(IE1_ADDR, 8'h20);
    @(posedge i_core_clk);
    i_wdt_expire <= 1'b1;
    @(posedge i_core_clk);
    i_wdt_expire <= 1'b0;
    @(negedge i_core_clk);
    chk("watchdog reset", 16'h0001, 16'(o_sys_reset));
    wait_taken(8'h05);
    chk("reset vector", VEC_RESET, last_vec);
    rd(IFG1_ADDR, 8'h03, "watchdog flag");
    rd(IE1_ADDR, 8'h00, "clear on reset");
    @(posedge i_core_clk);
    i_fetch_valid <= 1'b1;
    i_fetch_addr <= PERIPH_TOP;
    @(posedge i_core_clk);
    i_fetch_valid <= 1'b0;
    @(negedge i_core_clk);
    chk("fetch reset", 16'h0001, 16'(o_sys_reset));
    wait_taken(8'h06);
    @(posedge i_core_clk);
    i_boot_check <= 1'b1;
    i_boot_word <= BLANK_WORD;
    @(posedge i_core_clk);
    i_boot_check <= 1'b0;
    @(negedge i_core_clk);
    chk("blank vector", 16'(sleep_state_4), 16'(o_mode));
  endtask : t_resets
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    t_boot();
    t_modes();
    t_wake();
    t_interval();
    t_resets();
    conclude();
  end
endmodule : ilp_ctrl_test
